// *** rtl/sdpc_defs.vh ***
`ifndef SDPC_DEFS_VH
`define SDPC_DEFS_VH
// ----------------------------------------------------------------
// store location and word layout
// ----------------------------------------------------------------
`define SDPC_NVM_AW 8
`define SDPC_WORD_OFFSET 8'h20
`define SDPC_B_PIN0_VAL 0
`define SDPC_B_PIN1_VAL 1
`define SDPC_B_GIGA_DIS 4
`define SDPC_B_WD_PIN0 5
`define SDPC_B_PIN2_VAL 6
`define SDPC_B_PIN3_VAL 7
`define SDPC_B_PIN0_DIR 8
`define SDPC_B_PIN1_DIR 9
`define SDPC_B_SERIAL_EN 10
`define SDPC_B_DIS100 12
`define SDPC_B_PHY_OFF 13
`define SDPC_B_PIN2_DIR 14
`define SDPC_B_PIN3_DIR 15
// reset defaults of the word fields (only bit 13 is set)
`define SDPC_WORD_DEFAULT 16'h2000
// ----------------------------------------------------------------
// apb register map (byte addresses)
// ----------------------------------------------------------------
`define SDPC_A_WORD 8'h20
`define SDPC_A_PINS 8'h00
`define SDPC_A_MODE 8'h04
`define SDPC_A_STAT 8'h08
`define SDPC_A_RELOAD 8'h0c
// pins register fields
`define SDPC_P_VAL_LSB 0
`define SDPC_P_DIR_LSB 4
// mode register fields
`define SDPC_M_GIGA_DIS 0
`define SDPC_M_DIS100 1
`define SDPC_M_PHY_OFF 2
`define SDPC_M_SERIAL_EN 3
`define SDPC_M_WD_PIN0 4
// mode reset value: only the phy-off bit set
`define SDPC_MODE_DEFAULT 5'h04
// status register fields
`define SDPC_S_DONE 0
`define SDPC_S_BUSY 1
`endif

// *** rtl/sdpc_nvm_fetch.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"
// ----------------------------------------------------------------
// one-word fetch from the integrated store
// ----------------------------------------------------------------
module sdpc_nvm_fetch
(
  input wire pclk,
  input wire presetn,
  input wire start,
  output reg nvm_req,
  output reg [`SDPC_NVM_AW-1:0] nvm_addr,
  input wire nvm_ack,
  input wire [15:0] nvm_rdata,
  output reg done,
  output reg [15:0] word
);
  // request held until the store acknowledges; ack and data same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_req <= 1'b0;
      nvm_addr <= {`SDPC_NVM_AW{1'b0}};
      done <= 1'b0;
      word <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (start && !nvm_req)
      begin
        nvm_req <= 1'b1;
        nvm_addr <= `SDPC_WORD_OFFSET;
      end
      else if (nvm_req && nvm_ack)
      begin
        nvm_req <= 1'b0;
        word <= nvm_rdata;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/sdpc_loader.v ***
// Functional notes
// - fetch word at store offset 0x20
// - bit 15 seeds pin3 direction
// - bit 14 seeds pin2 direction
// - bit 13 powers phy off when disabled
// - bit 12 limits speed outside active state
// - bit 10 routes serial bus to pins
// - bit 10 seeds serial-on-pins enable
// - bit 9 seeds pin1 direction
// - bit 8 seeds pin0 direction
// - bit 7 seeds pin3 value, output only
// - bit 6 seeds pin2 value, output only
// - bit 5 puts watchdog on pin0 unless bit 10 is set
// - bit 4 disables gigabit entirely
// - bits 1,0 seed pin1/pin0 values
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"
module sdpc_loader
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg nvm_req,
  output reg [`SDPC_NVM_AW-1:0] nvm_addr,
  input wire nvm_ack,
  input wire [15:0] nvm_rdata,
  input wire watchdog_timeout,
  input wire serial_scl_drive,
  input wire serial_sda_drive,
  input wire [3:0] pin_in,
  output reg [3:0] pin_out,
  output reg [3:0] pin_oe,
  output reg [3:0] pin_sync_in,
  output reg giga_disable,
  output reg low_power_speed_limit,
  output reg phy_off_when_port_disabled,
  output reg serial_bus_on_pins_enable,
  output reg load_done
);
  // ----------------------------------------------------------------
  // loader sequencing
  // ----------------------------------------------------------------
  localparam [1:0] ST_START = 2'b00;
  localparam [1:0] ST_FETCH = 2'b01;
  localparam [1:0] ST_APPLY = 2'b10;
  localparam [1:0] ST_READY = 2'b11;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] word_reg;
  reg [3:0] pin_direction_reg;
  reg [3:0] pin_output_reg;
  reg [4:0] mode_reg;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  wire fetch_start;
  wire fetch_done;
  wire [15:0] fetch_word;
  wire fetch_req;
  wire [`SDPC_NVM_AW-1:0] fetch_addr;
  wire ready_now;
  wire access;
  wire [31:0] rd_word;
  assign ready_now = (state_reg == ST_READY);
  assign access = psel && penable;
  assign fetch_start = (state_reg == ST_START);
  sdpc_nvm_fetch u_fetch
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(fetch_start),
    .nvm_req(fetch_req),
    .nvm_addr(fetch_addr),
    .nvm_ack(nvm_ack),
    .nvm_rdata(nvm_rdata),
    .done(fetch_done),
    .word(fetch_word)
  );
  // the store handshake passes straight through from the fetch unit, whose flops keep it registered
  always @*
  begin
    nvm_req = fetch_req;
    nvm_addr = fetch_addr;
  end
  // next state; software reload restarts the fetch
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_START: state_next = ST_FETCH;
      ST_FETCH:
        if (fetch_done)
          state_next = ST_APPLY;
      ST_APPLY: state_next = ST_READY;
      ST_READY:
        // reload only at the edge that completes the transfer
        if (access && pready && pwrite && paddr == `SDPC_A_RELOAD && pwdata[0])
          state_next = ST_START;
      default: state_next = ST_START;
    endcase
  end
  // ----------------------------------------------------------------
  // seeding of control bits from the word
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_START;
      word_reg <= `SDPC_WORD_DEFAULT;
      pin_direction_reg <= 4'h0;
      pin_output_reg <= 4'h0;
      mode_reg <= `SDPC_MODE_DEFAULT;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_FETCH && fetch_done)
        word_reg <= fetch_word;
      if (state_reg == ST_APPLY)
      begin
        // bit 11 is reserved and never copied
        pin_direction_reg[3] <= word_reg[`SDPC_B_PIN3_DIR];
        pin_direction_reg[2] <= word_reg[`SDPC_B_PIN2_DIR];
        pin_direction_reg[1] <= word_reg[`SDPC_B_PIN1_DIR];
        pin_direction_reg[0] <= word_reg[`SDPC_B_PIN0_DIR];
        pin_output_reg[3] <= word_reg[`SDPC_B_PIN3_VAL];
        pin_output_reg[2] <= word_reg[`SDPC_B_PIN2_VAL];
        pin_output_reg[1] <= word_reg[`SDPC_B_PIN1_VAL];
        pin_output_reg[0] <= word_reg[`SDPC_B_PIN0_VAL];
        mode_reg[`SDPC_M_GIGA_DIS] <= word_reg[`SDPC_B_GIGA_DIS];
        mode_reg[`SDPC_M_DIS100] <= word_reg[`SDPC_B_DIS100];
        mode_reg[`SDPC_M_PHY_OFF] <= word_reg[`SDPC_B_PHY_OFF];
        mode_reg[`SDPC_M_SERIAL_EN] <= word_reg[`SDPC_B_SERIAL_EN];
        mode_reg[`SDPC_M_WD_PIN0] <= word_reg[`SDPC_B_WD_PIN0];
      end
      else if (ready_now && access && pready && pwrite)
      begin
        // software overrides only after the load, at the completing edge
        if (paddr == `SDPC_A_PINS)
        begin
          pin_output_reg <= pwdata[`SDPC_P_VAL_LSB+3:`SDPC_P_VAL_LSB];
          pin_direction_reg <= pwdata[`SDPC_P_DIR_LSB+3:`SDPC_P_DIR_LSB];
        end
        if (paddr == `SDPC_A_MODE)
          mode_reg <= pwdata[4:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // pin drive and status outputs
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
      giga_disable <= 1'b0;
      low_power_speed_limit <= 1'b0;
      phy_off_when_port_disabled <= 1'b1;
      serial_bus_on_pins_enable <= 1'b0;
      load_done <= 1'b0;
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      pin_sync_in <= 4'h0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      pin_sync_in <= sync2_reg;
      load_done <= ready_now;
      giga_disable <= mode_reg[`SDPC_M_GIGA_DIS];
      low_power_speed_limit <= mode_reg[`SDPC_M_DIS100];
      phy_off_when_port_disabled <= mode_reg[`SDPC_M_PHY_OFF];
      serial_bus_on_pins_enable <= mode_reg[`SDPC_M_SERIAL_EN];
      // a value is driven only while its pin is an output
      pin_out[3] <= pin_output_reg[3];
      pin_oe[3] <= pin_direction_reg[3];
      pin_out[1] <= pin_output_reg[1];
      pin_oe[1] <= pin_direction_reg[1];
      if (mode_reg[`SDPC_M_SERIAL_EN])
      begin
        // open-drain serial lines: drive low only
        pin_out[0] <= 1'b0;
        pin_oe[0] <= serial_scl_drive;
        pin_out[2] <= 1'b0;
        pin_oe[2] <= serial_sda_drive;
      end
      else
      begin
        pin_out[2] <= pin_output_reg[2];
        pin_oe[2] <= pin_direction_reg[2];
        if (mode_reg[`SDPC_M_WD_PIN0])
        begin
          pin_out[0] <= watchdog_timeout;
          pin_oe[0] <= 1'b1;
        end
        else
        begin
          pin_out[0] <= pin_output_reg[0];
          pin_oe[0] <= pin_direction_reg[0];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `SDPC_A_WORD) || (a == `SDPC_A_PINS) || (a == `SDPC_A_MODE) ||
                  (a == `SDPC_A_STAT) || (a == `SDPC_A_RELOAD);
    end
  endfunction
  assign rd_word = (paddr == `SDPC_A_WORD) ? {16'h0000, word_reg} :
                   (paddr == `SDPC_A_PINS) ? {24'h000000, pin_direction_reg, pin_output_reg} :
                   (paddr == `SDPC_A_MODE) ? {27'h0000000, mode_reg} :
                   (paddr == `SDPC_A_STAT) ? {30'h00000000, !ready_now, ready_now} :
                   32'h00000000;
  // access waits while loading so nothing sees half-seeded bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && !pready && ready_now)
      begin
        pready <= penable;
        pslverr <= penable && !is_mapped(paddr);
        prdata <= (penable && !pwrite) ? rd_word : 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/sdpc_loader_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"
// ------------------------------
// seeding checks
// ------------------------------
module sdpc_loader_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic nvm_req,
  input wire logic [`SDPC_NVM_AW-1:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic [15:0] nvm_rdata,
  input wire logic [3:0] pin_oe,
  input wire logic giga_disable,
  input wire logic low_power_speed_limit,
  input wire logic phy_off_when_port_disabled,
  input wire logic serial_bus_on_pins_enable,
  input wire logic load_done
);
  logic [15:0] w_reg;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // keep the word the store handed over, the seeds must match it
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      w_reg <= 16'h0000;
    else if (nvm_ack)
      w_reg <= nvm_rdata;
  sequence s_ack;
    nvm_req && nvm_ack;
  endsequence
  sequence s_seed;
    $rose(load_done);
  endsequence
  AST_ADDR: assert property (nvm_req |-> nvm_addr == `SDPC_WORD_OFFSET) else $error("bad fetch address");
  AST_DIR3: assert property (s_seed |-> pin_oe[3] == w_reg[15]) else $error("pin3 dir");
  AST_PHY: assert property (s_seed |-> phy_off_when_port_disabled == w_reg[13]) else $error("phy off");
  AST_DIS100: assert property (s_seed |-> low_power_speed_limit == w_reg[12]) else $error("speed limit");
  AST_SER: assert property (s_seed |-> serial_bus_on_pins_enable == w_reg[10]) else $error("serial en");
  AST_DIR1: assert property (s_seed |-> pin_oe[1] == w_reg[9]) else $error("pin1 dir");
  AST_GIGA: assert property (s_seed |-> giga_disable == w_reg[4]) else $error("giga");
  AST_STALL: assert property (!load_done |-> !pready) else $error("answer before load");
  AST_LOAD: assert property (s_ack |-> ##[1:4] load_done) else $error("load slow");
endmodule
bind sdpc_loader sdpc_loader_checker chk_u (.pclk, .presetn, .pready, .nvm_req, .nvm_addr, .nvm_ack,
  .nvm_rdata, .pin_oe, .giga_disable, .low_power_speed_limit, .phy_off_when_port_disabled,
  .serial_bus_on_pins_enable, .load_done);
`default_nettype wire

// *** testbench/sdpc_nvm_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// store model
// ------------------------------
module sdpc_nvm_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [7:0] addr,
  input wire logic [15:0] word,
  input wire logic [3:0] dly,
  output logic ack,
  output logic [15:0] rdata
);
  logic [3:0] cnt_reg;
  // answer after dly cycles; data toggles off the ack so stale words show
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ack <= 1'b0;
      cnt_reg <= 4'h0;
      rdata <= 16'h0000;
    end
    else if (req && !ack && cnt_reg == dly)
    begin
      ack <= 1'b1;
      cnt_reg <= 4'h0;
      rdata <= (addr == 8'h20) ? word : ~word;
    end
    else
    begin
      ack <= 1'b0;
      cnt_reg <= (req && !ack) ? cnt_reg + 4'h1 : 4'h0;
      rdata <= ~rdata;
    end
endmodule
`default_nettype wire

// *** testbench/sdpc_loader_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdpc_loader_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_req, nvm_ack, wd, scl, sda, load_done;
  logic [7:0] paddr, nvm_addr;
  logic [31:0] pwdata, prdata;
  logic [15:0] nvm_rdata, nv_word;
  logic [3:0] nv_dly, pin_in, pin_out, pin_oe, sync_in, modes;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [15:0] words [5] = '{16'h0000, 16'hffff, 16'h2000, 16'hc0b1, 16'h3742};
  sdpc_loader dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .nvm_req, .nvm_addr, .nvm_ack, .nvm_rdata, .watchdog_timeout(wd), .serial_scl_drive(scl),
    .serial_sda_drive(sda), .pin_in, .pin_out, .pin_oe, .pin_sync_in(sync_in), .giga_disable(modes[3]),
    .low_power_speed_limit(modes[2]), .phy_off_when_port_disabled(modes[1]),
    .serial_bus_on_pins_enable(modes[0]), .load_done);
  sdpc_nvm_model nvm_u (.clk(pclk), .rst_n(presetn), .req(nvm_req), .addr(nvm_addr), .word(nv_word),
    .dly(nv_dly), .ack(nvm_ack), .rdata(nvm_rdata));
  // 250 MHz
  always #2 pclk = ~pclk;
  task end_of_test;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // one transfer, then an idle edge so back-to-back calls never reassign psel in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      n_mismatch++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk_all(input logic [15:0] w);
    logic [31:0] r;
    logic e;
    chk(pin_oe, {w[15], w[10] ? sda : w[14], w[9], w[10] ? scl : w[5] | w[8]});
    chk(pin_out & pin_oe, {w[7] & w[15], !w[10] & w[6] & w[14], w[1] & w[9],
      !w[10] & (w[5] ? wd : w[0] & w[8])});
    chk(modes, {w[4], w[12], w[13], w[10]});
    apb(0, 8'h04, 0, r, e);
    chk(r, {w[5], w[10], w[13], w[12], w[4]});
    apb(0, 8'h00, 0, r, e);
    chk(r, {w[15:14], w[9:8], w[7:6], w[1:0]});
  endtask
  // reset, then read at once: the answer must wait for the load
  task s_load(input logic [15:0] w, input logic [3:0] dl);
    logic [31:0] r;
    logic e;
    nv_word <= w;
    nv_dly <= dl;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h20, 0, r, e);
    chk(load_done, 1);
    chk(r, {16'h0000, w});
    chk_all(w);
  endtask
  task s_ro_err;
    logic [31:0] r;
    logic e;
    apb(1, 8'h20, 32'h0000ffff, r, e);
    apb(0, 8'h20, 0, r, e);
    chk(r, {16'h0000, words[4]});
    apb(0, 8'h10, 0, r, e);
    chk(e, 1);
    apb(1, 8'h00, 32'h0000005a, r, e);
    apb(0, 8'h00, 0, r, e);
    chk(r, 32'h0000005a);
  endtask
  // reload replaces the hand-written pins with the new word
  task s_reload(input logic [15:0] w);
    logic [31:0] r;
    logic e;
    nv_word <= w;
    apb(1, 8'h0c, 1, r, e);
    apb(0, 8'h20, 0, r, e);
    chk(r, {16'h0000, w});
    chk_all(w);
  endtask
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    wd = 0;
    scl = 0;
    sda = 0;
    pin_in = 4'h9;
    nv_word = 0;
    nv_dly = 0;
    for (int i = 0; i < 5; i++)
    begin
      wd <= i[0];
      scl <= i[1];
      sda <= !i[0];
      s_load(words[i], i[3:0]);
    end
    s_ro_err();
    s_reload(16'h8830);
    chk(sync_in, 4'h9);
    end_of_test();
  end
endmodule
`default_nettype wire
